// ==== gpio_port.sv ====
// Chosen here: the register offsets and the AXI4-Lite register port.
`timescale 1ns/1ps
module gpio_port
   import gpio_pkg::*;
#(
   parameter int PINS = GPIO_PINS
) (
   input  wire logic              clk,
   input  wire logic              reset,
   input  wire logic [3:0]        s_axi_awaddr,
   input  wire logic              s_axi_awvalid,
   output logic                   s_axi_awready,
   input  wire logic [31:0]       s_axi_wdata,
   input  wire logic [3:0]        s_axi_wstrb,
   input  wire logic              s_axi_wvalid,
   output logic                   s_axi_wready,
   output logic [1:0]             s_axi_bresp,
   output logic                   s_axi_bvalid,
   input  wire logic              s_axi_bready,
   input  wire logic [3:0]        s_axi_araddr,
   input  wire logic              s_axi_arvalid,
   output logic                   s_axi_arready,
   output logic [31:0]            s_axi_rdata,
   output logic [1:0]             s_axi_rresp,
   output logic                   s_axi_rvalid,
   input  wire logic              s_axi_rready,
   input  wire logic [PINS-1:0]   pin_i,
   output logic      [PINS-1:0]   pin_o,
   output logic      [PINS-1:0]   pin_oe,
   output logic      [PINS-1:0]   pin_pullup_en,
   input  wire logic              sleep_clamp,
   input  wire logic [PINS-1:0]   ext_irq_enable,
   input  wire logic [PINS-1:0]   ext_irq_edge_mode,
   output logic      [PINS-1:0]   wake_irq_flag_set
);

   // ----------------------------------------------------------------------
   // Parameter check
   // ----------------------------------------------------------------------
   if (PINS != GPIO_PINS) begin : g_bad_pins
      $error("gpio_port supports exactly eight pins");
   end

   // ----------------------------------------------------------------------
   // Registers
   // ----------------------------------------------------------------------
   logic [PINS-1:0] drive_register_r;
   logic [PINS-1:0] direction_register_r;
   logic [PINS-1:0] sampled_input_register_r;
   logic [PINS-1:0] sync_latch_r;
   logic [7:0]      shared_function_register_r;
   logic [PINS-1:0] pin_in_meta_r;
   logic            clamp_meta_r;
   logic            clamp_r;
   logic            clamp_d_r;
   logic            global_pullup_off;
   logic [PINS-1:0] pad_view;
   logic [PINS-1:0] schmitt_in;
   gpio_pad_t       pad_nxt;

   assign global_pullup_off = shared_function_register_r[GPIO_PULLUP_OFF_POS];

   // ----------------------------------------------------------------------
   // AXI4-Lite write channel
   // ----------------------------------------------------------------------
   logic       aw_held_r;
   logic       w_held_r;
   logic [3:0] aw_addr_r;
   logic [7:0] w_data_r;
   logic       w_lane0_r;
   logic       do_write;

   assign do_write = aw_held_r && w_held_r && !s_axi_bvalid;

   always_ff @(posedge clk or posedge reset) begin
      if (reset) begin
         aw_held_r     <= 1'b0;
         s_axi_awready <= 1'b0;
         aw_addr_r     <= 4'h0;
      end else if (s_axi_awvalid && s_axi_awready) begin
         aw_held_r     <= 1'b1;
         s_axi_awready <= 1'b0;
         aw_addr_r     <= s_axi_awaddr;
      end else if (do_write) begin
         aw_held_r     <= 1'b0;
      end else begin
         s_axi_awready <= !aw_held_r && !s_axi_bvalid;
      end
   end

   always_ff @(posedge clk or posedge reset) begin
      if (reset) begin
         w_held_r     <= 1'b0;
         s_axi_wready <= 1'b0;
         w_data_r     <= 8'h00;
         w_lane0_r    <= 1'b0;
      end else if (s_axi_wvalid && s_axi_wready) begin
         w_held_r     <= 1'b1;
         s_axi_wready <= 1'b0;
         w_data_r     <= s_axi_wdata[7:0];
         w_lane0_r    <= s_axi_wstrb[0];
      end else if (do_write) begin
         w_held_r     <= 1'b0;
      end else begin
         s_axi_wready <= !w_held_r && !s_axi_bvalid;
      end
   end

   always_ff @(posedge clk or posedge reset) begin
      if (reset) begin
         s_axi_bvalid <= 1'b0;
         s_axi_bresp  <= GPIO_RESP_OKAY;
      end else if (do_write) begin
         s_axi_bvalid <= 1'b1;
         if (aw_addr_r == GPIO_OFS_SAMPLED) begin
            s_axi_bresp <= GPIO_RESP_SLVERR;
         end else if (aw_addr_r == GPIO_OFS_DRIVE || aw_addr_r == GPIO_OFS_DIR ||
                      aw_addr_r == GPIO_OFS_SHARED) begin
            s_axi_bresp <= GPIO_RESP_OKAY;
         end else begin
            s_axi_bresp <= GPIO_RESP_SLVERR;
         end
      end else if (s_axi_bready) begin
         s_axi_bvalid <= 1'b0;
      end
   end

   // Full-byte writes only; single-bit set/clear is a read-modify-write by
   // software, and storage is per bit so other pins never change.
   always_ff @(posedge clk or posedge reset) begin
      if (reset) begin
         drive_register_r           <= GPIO_RESET_VAL;
         direction_register_r       <= GPIO_RESET_VAL;
         shared_function_register_r <= GPIO_RESET_VAL;
      end else if (do_write && w_lane0_r) begin
         if (aw_addr_r == GPIO_OFS_DRIVE) begin
            drive_register_r <= w_data_r;
         end else if (aw_addr_r == GPIO_OFS_DIR) begin
            direction_register_r <= w_data_r;
         end else if (aw_addr_r == GPIO_OFS_SHARED) begin
            shared_function_register_r <= w_data_r;
         end
      end
   end

   // ----------------------------------------------------------------------
   // AXI4-Lite read channel
   // ----------------------------------------------------------------------
   always_ff @(posedge clk or posedge reset) begin
      if (reset) begin
         s_axi_arready <= 1'b0;
         s_axi_rvalid  <= 1'b0;
         s_axi_rdata   <= 32'h0000_0000;
         s_axi_rresp   <= GPIO_RESP_OKAY;
      end else if (s_axi_arvalid && s_axi_arready) begin
         s_axi_arready <= 1'b0;
         s_axi_rvalid  <= 1'b1;
         s_axi_rresp   <= GPIO_RESP_OKAY;
         if (s_axi_araddr == GPIO_OFS_DRIVE) begin
            s_axi_rdata <= {24'h000000, drive_register_r};
         end else if (s_axi_araddr == GPIO_OFS_DIR) begin
            s_axi_rdata <= {24'h000000, direction_register_r};
         end else if (s_axi_araddr == GPIO_OFS_SAMPLED) begin
            s_axi_rdata <= {24'h000000, sampled_input_register_r};
         end else if (s_axi_araddr == GPIO_OFS_SHARED) begin
            s_axi_rdata <= {24'h000000, shared_function_register_r};
         end else begin
            s_axi_rdata <= 32'h0000_0000;
            s_axi_rresp <= GPIO_RESP_SLVERR;
         end
      end else if (s_axi_rvalid) begin
         if (s_axi_rready) begin
            s_axi_rvalid <= 1'b0;
         end
      end else begin
         s_axi_arready <= 1'b1;
      end
   end

   // ----------------------------------------------------------------------
   // Pad control, one generate per pin
   // ----------------------------------------------------------------------
   genvar n;
   for (n = 0; n < PINS; n++) begin : g_pin
      always_comb begin
         pad_nxt.pin_oe[n]    = direction_register_r[n];
         pad_nxt.pin_o[n]     = direction_register_r[n] & drive_register_r[n];
         pad_nxt.pullup_en[n] = !direction_register_r[n] && drive_register_r[n] &&
                                !global_pullup_off;
      end
      // The pad sees our own drive directly, so read-back of a written level
      // arrives with only the synchroniser delay.
      assign pad_view[n]   = direction_register_r[n] ? drive_register_r[n] : pin_in_meta_r[n];
      assign schmitt_in[n] = pad_view[n] & !(clamp_r & !ext_irq_enable[n]);
   end

   // Pad outputs are registered copies; reset clears them asynchronously.
   // Each pin is driven only from its own bits, so other functions on
   // neighbouring pins never disturb it.
   always_ff @(posedge clk or posedge reset) begin
      if (reset) begin
         pin_o         <= GPIO_RESET_VAL;
         pin_oe        <= GPIO_RESET_VAL;
         pin_pullup_en <= GPIO_RESET_VAL;
      end else begin
         pin_o         <= pad_nxt.pin_o;
         pin_oe        <= pad_nxt.pin_oe;
         pin_pullup_en <= pad_nxt.pullup_en;
      end
   end

   // ----------------------------------------------------------------------
   // Input synchroniser
   // ----------------------------------------------------------------------
   // A clock-high latch is modelled as a falling-edge capture: same value
   // presented to the rising-edge register, without a real latch cell.
   always_ff @(posedge clk or posedge reset) begin
      if (reset) begin
         pin_in_meta_r <= GPIO_RESET_VAL;
         clamp_meta_r  <= 1'b0;
         clamp_r       <= 1'b0;
         clamp_d_r     <= 1'b0;
      end else begin
         pin_in_meta_r <= pin_i;
         clamp_meta_r  <= sleep_clamp;
         clamp_r       <= clamp_meta_r;
         clamp_d_r     <= clamp_r;
      end
   end

   always_ff @(negedge clk or posedge reset) begin
      if (reset) begin
         sync_latch_r <= GPIO_RESET_VAL;
      end else begin
         sync_latch_r <= schmitt_in;
      end
   end

   always_ff @(posedge clk or posedge reset) begin
      if (reset) begin
         sampled_input_register_r <= GPIO_RESET_VAL;
      end else begin
         sampled_input_register_r <= sync_latch_r;
      end
   end

   // ----------------------------------------------------------------------
   // Wake-up edge
   // ----------------------------------------------------------------------
   // Releasing the clamp looks like a rising edge on a high pin.
   always_ff @(posedge clk or posedge reset) begin
      if (reset) begin
         wake_irq_flag_set <= GPIO_RESET_VAL;
      end else if (clamp_d_r && !clamp_r) begin
         wake_irq_flag_set <= pad_view & ext_irq_edge_mode & ~ext_irq_enable;
      end else begin
         wake_irq_flag_set <= GPIO_RESET_VAL;
      end
   end

endmodule

// ==== gpio_pkg.sv ====
// Functional notes
// - Per port: drive, direction (rw), sampled input (ro).
// - Global pull-up off disables every pull-up.
// - Direction one means output, zero input.
// - Input with drive bit one enables pull-up.
// - Reset tri-states pins without a clock.
// - Output drives the drive bit level.
// - Input high impedance unless pull-up enabled.
// - Sampled bit shows synchronised pin, zero while clamped.
// - Clock-high latch, then register on rise.
// - Written level readable one period later.
// - Enabled external interrupt pin escapes clamp.
// - Wake sets flag for high edge pin.
// - Alternate function leaves other pins usable.
// - Bit set/clear touches only target bit.
// - Pull-up off at bit 2 of shared register.
package gpio_pkg;

   // ----------------------------------------------------------------------
   // Register map
   // ----------------------------------------------------------------------
   localparam logic [3:0] GPIO_OFS_DRIVE   = 4'h0;
   localparam logic [3:0] GPIO_OFS_DIR     = 4'h4;
   localparam logic [3:0] GPIO_OFS_SAMPLED = 4'h8;
   localparam logic [3:0] GPIO_OFS_SHARED  = 4'hC;
   localparam logic [3:0] GPIO_OFS_BITSET  = 4'h0;
   localparam int         GPIO_PULLUP_OFF_POS = 2;
   localparam logic [7:0] GPIO_RESET_VAL   = 8'h00;
   localparam logic [1:0] GPIO_RESP_OKAY   = 2'h0;
   localparam logic [1:0] GPIO_RESP_SLVERR = 2'h2;
   localparam int         GPIO_PINS        = 8;

   typedef struct packed {
      logic [7:0] pin_o;
      logic [7:0] pin_oe;
      logic [7:0] pullup_en;
   } gpio_pad_t;

endpackage

// ==== gpio_port_props.sv ====
`timescale 1ns/1ps
module gpio_port_props
   import gpio_pkg::*;
#(
   parameter int PINS = GPIO_PINS
) (
   input wire logic            clk,
   input wire logic            reset,
   input wire logic            s_axi_bvalid,
   input wire logic            s_axi_bready,
   input wire logic            s_axi_arvalid,
   input wire logic            s_axi_arready,
   input wire logic [31:0]     s_axi_rdata,
   input wire logic            s_axi_rvalid,
   input wire logic            s_axi_rready,
   input wire logic [PINS-1:0] pin_o,
   input wire logic [PINS-1:0] pin_oe,
   input wire logic [PINS-1:0] pin_pullup_en,
   input wire logic [PINS-1:0] ext_irq_enable,
   input wire logic [PINS-1:0] wake_irq_flag_set
);
   default clocking @(posedge clk); endclocking
   default disable iff (reset);
   // Reset must tri-state the pins, so this one is deliberately not disabled by reset.
   chk_reset_tri_state: assert property (disable iff (1'b0) reset |-> pin_oe == '0 && pin_pullup_en == '0)
      else $error("pins not released in reset");
   chk_low_unless_out: assert property ((pin_o & ~pin_oe) == '0)
      else $error("pin driven high while input");
   chk_pullup_input: assert property ((pin_pullup_en & pin_oe) == '0)
      else $error("pull-up on an output pin");
   chk_wake_one_cycle: assert property (|wake_irq_flag_set |=> wake_irq_flag_set == '0)
      else $error("wake flag longer than one cycle");
   chk_wake_irq_off: assert property ((wake_irq_flag_set & ext_irq_enable) == '0)
      else $error("wake flag on enabled interrupt pin");
   chk_read_answer: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
      else $error("read answer late");
   chk_read_hold: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
      else $error("read data dropped");
   chk_read_upper_zero: assert property (s_axi_rvalid |-> s_axi_rdata[31:8] == '0)
      else $error("upper read bits set");
   chk_write_resp_hold: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid)
      else $error("write response dropped");
endmodule
bind gpio_port gpio_port_props #(.PINS(PINS)) i_props (.clk(clk), .reset(reset),
   .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready), .s_axi_arvalid(s_axi_arvalid),
   .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata), .s_axi_rvalid(s_axi_rvalid),
   .s_axi_rready(s_axi_rready), .pin_o(pin_o), .pin_oe(pin_oe), .pin_pullup_en(pin_pullup_en),
   .ext_irq_enable(ext_irq_enable), .wake_irq_flag_set(wake_irq_flag_set));

// ==== gpio_pins_model.sv ====
`timescale 1ns/1ps
module gpio_pins_model (
   input  wire logic       clk,
   input  wire logic [7:0] pin_o,
   input  wire logic [7:0] pin_oe,
   input  wire logic [7:0] pull_en,
   input  wire logic [7:0] ext_en,
   input  wire logic [7:0] ext_val,
   output logic      [7:0] pad
);
   // A floating pad flips every cycle, so a design reading it never sees a steady level.
   logic [7:0] float_r = 8'h55;
   always @(posedge clk) float_r <= ~float_r;
   always_comb begin
      for (int i = 0; i < 8; i++) begin
         if (pin_oe[i]) pad[i] = pin_o[i];
         else if (ext_en[i]) pad[i] = ext_val[i];
         else if (pull_en[i]) pad[i] = 1'b1;
         else pad[i] = float_r[i];
      end
   end
endmodule

// ==== general_purpose_io_port_test.sv ====
`timescale 1ns/1ps
module general_purpose_io_port_test;
   import gpio_pkg::*;
   logic        clk = 0, reset = 1, awvalid = 0, wvalid = 0, bready = 0, arvalid = 0;
   logic        rready = 0, clamp = 0, p, awready, wready, bvalid, arready, rvalid;
   logic [3:0]  awaddr = 0, araddr = 0, wstrb = 0;
   logic [31:0] wdata = 0, rdata, rd;
   logic [1:0]  bresp, rresp, resp;
   logic [7:0]  pad, pin_o, pin_oe, pull, wake, d, r, m, seen;
   logic [7:0]  ext_en = 0, ext_val = 0, irq_en = 0, edge_m = 0;
   integer      seed = 32'hEE9C, fail_count = 0, num_checks = 0, cycles = 0;
   always #5 clk = ~clk;
   gpio_port i_dut (.clk(clk), .reset(reset), .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
      .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid),
      .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
      .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
      .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
      .pin_i(pad), .pin_o(pin_o), .pin_oe(pin_oe), .pin_pullup_en(pull), .sleep_clamp(clamp),
      .ext_irq_enable(irq_en), .ext_irq_edge_mode(edge_m), .wake_irq_flag_set(wake));
   gpio_pins_model i_pins (.clk(clk), .pin_o(pin_o), .pin_oe(pin_oe), .pull_en(pull),
      .ext_en(ext_en), .ext_val(ext_val), .pad(pad));
   function automatic logic [7:0] pin_exp(input logic [7:0] dr, dv, en, ev, input logic pu);
      return (dr & dv) | (~dr & en & ev) | (~dr & ~en & dv & {8{~pu}});
   endfunction
   task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
      num_checks++;
      if (g !== e) begin
         fail_count++;
         $display("wrong value %s expected %h seen %h", n, e, g);
      end
   endtask
   task automatic wr(input logic [3:0] a, input logic [7:0] v, input logic [3:0] s = 4'hF);
      @(posedge clk);
      awaddr <= a;
      wdata <= {24'h0, v};
      wstrb <= s;
      awvalid <= 1;
      wvalid <= 1;
      bready <= 1;
      forever begin
         @(posedge clk);
         if (awready) awvalid <= 0;
         if (wready) wvalid <= 0;
         if (bvalid) break;
      end
      resp = bresp;
      bready <= 0;
   endtask
   task automatic rd_reg(input logic [3:0] a);
      @(posedge clk);
      araddr <= a;
      arvalid <= 1;
      rready <= 1;
      forever begin
         @(posedge clk);
         if (arready) arvalid <= 0;
         if (rvalid) break;
      end
      rd = rdata;
      resp = rresp;
      rready <= 0;
   endtask
   task automatic stop_test;
      $display("checks %0d mismatches %0d", num_checks, fail_count);
      if (fail_count == 0 && num_checks > 0) $display("== PASSED ==");
      else $display("== FAILED ==");
      $finish;
   endtask
   always @(posedge clk) begin
      cycles++;
      if (cycles == 20000) begin
         fail_count++;
         stop_test;
      end
   end
   initial begin
      repeat (20) @(posedge clk);
      chk("oe_in_reset", 0, pin_oe);
      reset <= 0;
      foreach (d[i]) if (i < 3) begin
         rd_reg(i == 2 ? GPIO_OFS_SHARED : 4'(i * 4));
         chk("reset_value", GPIO_RESET_VAL, rd);
      end
      for (int k = 0; k < 40; k++) begin
         d = $random(seed);
         r = $random(seed);
         m = $random(seed);
         p = $random(seed);
         ext_en <= m;
         ext_val <= $random(seed);
         wr(GPIO_OFS_SHARED, 8'(p) << GPIO_PULLUP_OFF_POS);
         // Drive before direction, so each pin passes through a middle state.
         wr(GPIO_OFS_DRIVE, d);
         wr(GPIO_OFS_DIR, r);
         repeat (4) @(posedge clk);
         chk("pin_oe", r, pin_oe);
         chk("pin_o", d & r, pin_o);
         chk("pullup", ~r & d & {8{~p}}, pull);
         rd_reg(GPIO_OFS_SAMPLED);
         chk("sampled", pin_exp(r, d, m, ext_val, p), rd & (r | m | d & {8{~p}}));
         rd_reg(GPIO_OFS_DRIVE);
         chk("drive_back", d, rd);
         r = r ^ (8'h01 << (k % 8));
         wr(GPIO_OFS_DIR, r);
         repeat (3) @(posedge clk);
         chk("single_bit", r, pin_oe);
      end
      wr(GPIO_OFS_SAMPLED, 8'hFF);
      chk("ro_resp", GPIO_RESP_SLVERR, resp);
      wr(GPIO_OFS_DRIVE, ~d, 4'h0);
      rd_reg(GPIO_OFS_DRIVE);
      chk("no_strobe", d, rd);
      wr(GPIO_OFS_DIR, 8'h00);
      ext_en <= 8'hFF;
      ext_val <= 8'hF0;
      irq_en <= 8'h30;
      edge_m <= 8'h50;
      clamp <= 1;
      repeat (6) @(posedge clk);
      rd_reg(GPIO_OFS_SAMPLED);
      chk("clamped", 8'h30, rd);
      clamp <= 0;
      seen = 0;
      repeat (8) @(posedge clk) seen |= wake;
      chk("wake_flag", 8'h40, seen);
      stop_test;
   end
endmodule
